// ---- rtl/audio_mux_mixer_router.sv ----
// audio mux/demux, eight-channel mixer, meters, monitor pick and delay line
// assumes tick, aes and embedded inputs come from logic on this clock
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps

module audio_mux_mixer_router #(
  parameter int DELAY_MAX_MS = mix_pkg::DELAY_MS_DFLT
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic [7:0]          addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [31:0]              rdata,
  input  wire logic                tick,
  input  wire mix_pkg::aes_bus_t   aes_in,
  input  wire logic [3:0]          aes_in_valid,
  input  wire logic [3:0][2:0]     aes_kind,
  input  wire mix_pkg::emb_bus_t   emb_in,
  input  wire logic [3:0]          emb_present,
  output mix_pkg::aes_bus_t        aes_out,
  output logic [3:0]               aes_dir,
  output mix_pkg::emb_bus_t        emb_out,
  output logic                     out_valid,
  output mix_pkg::sample_t         mon_l,
  output mix_pkg::sample_t         mon_r,
  output mix_pkg::sample_t         disp_l,
  output mix_pkg::sample_t         disp_r,
  output logic                     anlg_ref_hi,
  output logic [7:0]               peak_flag,
  output logic [7:0][1:0]          vu_level
);
  localparam int DEPTH = DELAY_MAX_MS * mix_pkg::SAMPLES_PER_MS + 1;
  localparam int PW    = $clog2(DEPTH);

  if (DELAY_MAX_MS < 1 || DELAY_MAX_MS > 1023) begin : g_chk
    $error("DELAY_MAX_MS must lie in 1..1023");
  end

  typedef enum logic [2:0] {S_IDLE, S_PROC, S_DONE, S_WRITE, S_EMIT} phase_t;

  typedef struct packed {
    phase_t                phase;
    logic [2:0]            idx;
    mix_pkg::cfg_t         cfg;
    logic [9:0]            dly_ms;
    logic [6:0]            vol;
    mix_pkg::chan_t [7:0]  ch;
    mix_pkg::aes_bus_t     hold;
    mix_pkg::aes_bus_t     src;
    mix_pkg::emb_bus_t     emb;
    logic [7:0][29:0]      acc;
    mix_pkg::aes_bus_t     mix;
    logic [PW-1:0]         wp;
    logic [2:0]            stat_a;
    logic [2:0]            stat_b;
    logic [3:0][2:0]       aes_stat;
    logic [3:0]            aes_dir;
    mix_pkg::aes_bus_t     aes_out;
    mix_pkg::emb_bus_t     emb_out;
    mix_pkg::sample_t      mon_l;
    mix_pkg::sample_t      mon_r;
    mix_pkg::sample_t      disp_l;
    mix_pkg::sample_t      disp_r;
    logic                  out_valid;
    logic [7:0]            peak;
    logic [7:0][1:0]       vu;
    logic [31:0]           rdata;
  } state_t;

  function automatic state_t rst_val();
    state_t s;
    s = '0;
    s.phase = S_IDLE;
    s.cfg = mix_pkg::CFG_RST;
    s.vol = mix_pkg::VOL_MAX;
    for (int i = 0; i < 8; i++) s.ch[i].route = 8'h01 << i;
    return s;
  endfunction

  localparam state_t ST_RST = rst_val();

  function automatic logic ch_hit(input logic [7:0] a);
    ch_hit = (a >= mix_pkg::REG_CH0) && (a <= mix_pkg::REG_CH7) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [23:0] mag(input mix_pkg::sample_t x);
    mag = x[23] ? 24'(-x) : 24'(x);
  endfunction

  function automatic mix_pkg::sample_t sat(input logic signed [29:0] a);
    if (a > 30'(mix_pkg::SAMPLE_MAX)) sat = mix_pkg::SAMPLE_MAX;
    else if (a < 30'(mix_pkg::SAMPLE_MIN)) sat = mix_pkg::SAMPLE_MIN;
    else sat = 24'(a);
  endfunction

  function automatic logic [1:0] vu_of(input logic [23:0] m, input logic ref18);
    logic [23:0] hi;
    logic [23:0] lo;
    hi = ref18 ? mix_pkg::REF_M18 : mix_pkg::REF_M20;
    lo = ref18 ? mix_pkg::REF_M38 : mix_pkg::REF_M40;
    vu_of = (m > hi) ? mix_pkg::VU_HIGH : (m > lo) ? mix_pkg::VU_PRES : mix_pkg::VU_NONE;
  endfunction

  function automatic mix_pkg::sample_t vscale(input mix_pkg::sample_t x,
                                              input logic [16:0] k);
    logic signed [41:0] m;
    m = 42'(x) * $signed({1'b0, k});
    vscale = 24'(m >>> 16);
  endfunction

  state_t              st;
  state_t              nxt;
  mix_pkg::aes_bus_t   dmem [DEPTH];
  mix_pkg::aes_bus_t   drd;
  mix_pkg::aes_bus_t   dout;
  mix_pkg::cfg_t       wc;
  mix_pkg::chan_t      wch;
  logic [PW:0]         dsamp;
  logic [PW-1:0]       rp;
  logic [2:0]          ci;
  logic                tied;
  logic signed [7:0]   gsel;
  logic [7:0]          u;
  logic [3:0]          q;
  logic [2:0]          r;
  logic signed [37:0]  prod;
  logic signed [51:0]  sh;
  logic signed [29:0]  v;
  logic [16:0]         vk;
  logic [3:0]          ea;
  logic [3:0]          eb;

  // delay read pointer trails the write pointer by the programmed millisecond count times SAMPLES_PER_MS
  assign dsamp = (PW+1)'(32'(st.dly_ms) * mix_pkg::SAMPLES_PER_MS);
  assign rp = PW'((st.wp >= dsamp) ? {1'b0, st.wp} - dsamp
                                   : {1'b0, st.wp} + (PW+1)'(DEPTH) - dsamp);

  // no reset on the delay store; stale words only show until it has filled
  always_ff @(posedge clock) begin
    if (st.phase == S_WRITE) begin
      dmem[st.wp] <= st.mix;
      drd <= dmem[rp];
    end
  end

  always_comb begin
    nxt = st;
    wc = st.cfg;
    wch = '0;
    ea = '0;
    eb = '0;
    ci = {st.idx[2:1], 1'b0};
    tied = st.ch[ci].tie | st.ch[ci + 3'h1].tie;
    gsel = tied ? st.ch[ci].gain_db : st.ch[st.idx].gain_db;
    u = 8'(gsel) + mix_pkg::GAIN_OFS;
    q = 4'(u / mix_pkg::DB_STEP);
    r = 3'(u % mix_pkg::DB_STEP);
    prod = st.src[st.idx] * $signed({1'b0, mix_pkg::GAIN_STEP[r]});
    sh = 52'(prod) <<< q;
    v = 30'(sh >>> 24);
    if (st.ch[st.idx].inv) v = -v;
    dout = (st.dly_ms == 10'h000) ? st.mix : drd;
    vk = 17'(st.vol) * 17'(mix_pkg::VOL_K);
    nxt.out_valid = 1'b0;

    // port direction and status follow the mode on every cycle
    if (st.cfg.mode == mix_pkg::MODE_DEMUX) nxt.aes_dir = 4'hF;
    else if (st.cfg.mode == mix_pkg::MODE_MUX4) nxt.aes_dir = 4'hC;
    else nxt.aes_dir = 4'h0;
    for (int p = 0; p < 4; p++) begin
      nxt.aes_stat[p] = nxt.aes_dir[p] ? mix_pkg::AES_OUT : aes_kind[p];
      if (aes_in_valid[p]) begin
        // zero-order hold at the frame rate stands in for rate conversion
        nxt.hold[2*p] = aes_in[2*p];
        nxt.hold[2*p+1] = aes_in[2*p+1];
      end
    end
    nxt.stat_a = emb_present[st.cfg.grp_a] ? 3'(st.cfg.grp_a) + 3'h1
                                           : mix_pkg::ST_NONE;
    if (st.cfg.mode == mix_pkg::MODE_MUX4 || st.cfg.grp_b == mix_pkg::GRP_OFF) begin
      nxt.stat_b = mix_pkg::ST_OFF;
    end else begin
      nxt.stat_b = emb_present[st.cfg.grp_b[1:0]] ? st.cfg.grp_b + 3'h1 : mix_pkg::ST_NONE;
    end

    case (st.phase)
      S_IDLE: begin
        // ticks that land while a frame is in flight are dropped
        if (tick) begin
          for (int i = 0; i < 4; i++) begin
            ea = {st.cfg.grp_a, 2'(i)};
            eb = {st.cfg.grp_b[1:0], 2'(i)};
            if (st.cfg.mode == mix_pkg::MODE_DEMUX) nxt.src[i] = emb_in[ea];
            else nxt.src[i] = st.hold[i];
            if (st.cfg.mode == mix_pkg::MODE_MUX8) nxt.src[i+4] = st.hold[i+4];
            else if (st.cfg.mode == mix_pkg::MODE_MUX4) nxt.src[i+4] = emb_in[ea];
            else if (st.cfg.grp_b == mix_pkg::GRP_OFF) nxt.src[i+4] = '0;
            else nxt.src[i+4] = emb_in[eb];
          end
          nxt.emb = emb_in;
          nxt.acc = '0;
          nxt.idx = 3'h0;
          nxt.phase = S_PROC;
        end
      end
      S_PROC: begin
        for (int j = 0; j < 8; j++) begin
          if (st.ch[st.idx].route[j]) nxt.acc[j] = st.acc[j] + 30'(v);
        end
        nxt.idx = st.idx + 3'h1;
        if (st.idx == 3'h7) nxt.phase = S_DONE;
      end
      S_DONE: begin
        for (int j = 0; j < 8; j++) nxt.mix[j] = sat($signed(st.acc[j]));
        nxt.phase = S_WRITE;
      end
      S_WRITE: begin
        nxt.wp = (32'(st.wp) == DEPTH - 1) ? '0 : st.wp + PW'(1);
        nxt.phase = S_EMIT;
      end
      S_EMIT: begin
        nxt.aes_out = '0;
        nxt.emb_out = st.emb;
        for (int i = 0; i < 4; i++) begin
          if (st.cfg.mode == mix_pkg::MODE_DEMUX) nxt.aes_out[i] = dout[i];
          if (st.cfg.mode != mix_pkg::MODE_MUX8) nxt.aes_out[i+4] = dout[i+4];
          if (st.cfg.mode != mix_pkg::MODE_DEMUX) begin
            nxt.emb_out[{st.cfg.grp_a, 2'(i)}] = dout[i];
          end
          if (st.cfg.mode == mix_pkg::MODE_MUX8 && st.cfg.grp_b != mix_pkg::GRP_OFF) begin
            nxt.emb_out[{st.cfg.grp_b[1:0], 2'(i)}] = dout[i+4];
          end
        end
        nxt.mon_l = vscale(nxt.emb_out[{st.cfg.mon_sel, 1'b0}], vk);
        nxt.mon_r = vscale(nxt.emb_out[{st.cfg.mon_sel, 1'b1}], vk);
        nxt.disp_l = nxt.emb_out[{st.cfg.disp_sel, 1'b0}];
        nxt.disp_r = nxt.emb_out[{st.cfg.disp_sel, 1'b1}];
        for (int k = 0; k < 8; k++) begin
          nxt.peak[k] = mag(st.mix[k]) >= mix_pkg::PEAK_THR[st.cfg.peak_sel];
          nxt.vu[k] = vu_of(mag(st.mix[k]), st.cfg.dig_ref);
        end
        nxt.out_valid = 1'b1;
        nxt.phase = S_IDLE;
      end
      default: nxt.phase = S_IDLE;
    endcase

    if (wr) begin
      if (addr == mix_pkg::REG_CFG) begin
        wc = mix_pkg::cfg_t'(wdata[17:0]);
        if (wc.mode == mix_pkg::MODE_BAD) wc.mode = st.cfg.mode;
        if (wc.grp_b > mix_pkg::GRP_OFF) wc.grp_b = mix_pkg::GRP_OFF;
        if (wc.peak_sel > mix_pkg::PEAK_SEL_MAX) wc.peak_sel = mix_pkg::PEAK_SEL_MAX;
        nxt.cfg = wc;
      end else if (addr == mix_pkg::REG_DELAY) begin
        nxt.dly_ms = (wdata > 32'(DELAY_MAX_MS)) ? 10'(DELAY_MAX_MS) : wdata[9:0];
      end else if (addr == mix_pkg::REG_VOL) begin
        nxt.vol = (wdata > 32'(mix_pkg::VOL_MAX)) ? mix_pkg::VOL_MAX : wdata[6:0];
      end else if (ch_hit(addr)) begin
        wch = mix_pkg::chan_t'(wdata[17:0]);
        if (wch.gain_db < mix_pkg::GAIN_MIN) wch.gain_db = mix_pkg::GAIN_MIN;
        if (wch.gain_db > mix_pkg::GAIN_MAX) wch.gain_db = mix_pkg::GAIN_MAX;
        nxt.ch[addr[4:2]] = wch;
      end
    end

    nxt.rdata = '0;
    if (rd) begin
      if (addr == mix_pkg::REG_CFG) nxt.rdata = 32'(st.cfg);
      else if (addr == mix_pkg::REG_DELAY) nxt.rdata = 32'(st.dly_ms);
      else if (addr == mix_pkg::REG_VOL) nxt.rdata = 32'(st.vol);
      else if (addr == mix_pkg::REG_STAT) nxt.rdata = 32'({st.aes_stat, st.stat_b, st.stat_a});
      else if (addr == mix_pkg::REG_LEVEL) nxt.rdata = 32'({st.vu, st.peak});
      else if (ch_hit(addr)) nxt.rdata = 32'(st.ch[addr[4:2]]);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) st <= ST_RST;
    else st <= nxt;
  end

  assign rdata       = st.rdata;
  assign aes_out     = st.aes_out;
  assign aes_dir     = st.aes_dir;
  assign emb_out     = st.emb_out;
  assign out_valid   = st.out_valid;
  assign mon_l       = st.mon_l;
  assign mon_r       = st.mon_r;
  assign disp_l      = st.disp_l;
  assign disp_r      = st.disp_r;
  assign anlg_ref_hi = st.cfg.anlg_ref;
  assign peak_flag   = st.peak;
  assign vu_level    = st.vu;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  mode_legal_a: assert property (st.cfg.mode != mix_pkg::MODE_BAD)
    else $error("port mode left the three legal settings");
  delay_cap_a: assert property (st.dly_ms <= 10'(DELAY_MAX_MS))
    else $error("audio delay above its ceiling");
  vol_cap_a: assert property (st.vol <= mix_pkg::VOL_MAX)
    else $error("monitor volume above full scale");
  dir_demux_a: assert property (st.cfg.mode == mix_pkg::MODE_DEMUX |=>
    aes_dir == 4'hF && st.aes_stat == {4{mix_pkg::AES_OUT}})
    else $error("demux pairs not all outputs");
  // the reset image shows no pair as output; skip the edge that releases reset
  dir_mux4_a: assert property (reset_n && st.cfg.mode == mix_pkg::MODE_MUX4 |=>
    aes_dir == 4'hC && st.aes_stat[3] == mix_pkg::AES_OUT && st.stat_b == mix_pkg::ST_OFF)
    else $error("four-in mode pair direction wrong");
  grp_b_off_a: assert property (st.cfg.grp_b == mix_pkg::GRP_OFF |=>
    st.stat_b == mix_pkg::ST_OFF)
    else $error("selector B off not reported");
  gain_range_a: assert property (st.phase == S_PROC |->
    gsel >= mix_pkg::GAIN_MIN && gsel <= mix_pkg::GAIN_MAX)
    else $error("channel gain outside range");
  frame_time_a: assert property (tick && st.phase == S_IDLE |->
    ##12 out_valid ##1 !out_valid)
    else $error("frame output not a pulse twelve cycles after tick");
  peak_chk_a: assert property (out_valid |->
    peak_flag[0] == (mag(st.mix[0]) >= mix_pkg::PEAK_THR[$past(st.cfg.peak_sel)]))
    else $error("peak flag disagrees with threshold");
  vu_chk_a: assert property (out_valid && !$past(st.cfg.dig_ref) |->
    (vu_level[1] == mix_pkg::VU_HIGH) == (mag(st.mix[1]) > mix_pkg::REF_M20))
    else $error("level high flag disagrees with reference");
endmodule

// ---- inc/mix_pkg.sv ----
// constants, register layout and sample carriers of the audio mixer/router
// assumes 24-bit two's complement samples, one 10 MHz clock, 48 kHz frame tick
package mix_pkg;
  typedef logic signed [23:0] sample_t;
  typedef sample_t [7:0]      aes_bus_t;
  typedef sample_t [15:0]     emb_bus_t;

  typedef struct packed {
    logic [2:0] disp_sel;
    logic [2:0] mon_sel;
    logic [2:0] grp_b;
    logic [1:0] grp_a;
    logic       anlg_ref;
    logic [2:0] peak_sel;
    logic       dig_ref;
    logic [1:0] mode;
  } cfg_t;

  typedef struct packed {
    logic [7:0]        route;
    logic              tie;
    logic              inv;
    logic signed [7:0] gain_db;
  } chan_t;

  localparam logic [7:0] REG_CFG   = 8'h00;
  localparam logic [7:0] REG_DELAY = 8'h04;
  localparam logic [7:0] REG_VOL   = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam logic [7:0] REG_LEVEL = 8'h10;
  localparam logic [7:0] REG_CH0   = 8'h20;
  localparam logic [7:0] REG_CH7   = 8'h3C;

  localparam logic [1:0] MODE_MUX4  = 2'h0;
  localparam logic [1:0] MODE_MUX8  = 2'h1;
  localparam logic [1:0] MODE_DEMUX = 2'h2;
  localparam logic [1:0] MODE_BAD   = 2'h3;
  localparam cfg_t       CFG_RST    = 18'h0_0000;

  localparam logic [2:0] GRP_OFF      = 3'h4;
  localparam logic [2:0] PEAK_SEL_MAX = 3'h5;
  localparam logic [2:0] ST_NONE      = 3'h0;
  localparam logic [2:0] ST_OFF       = 3'h5;
  localparam logic [2:0] AES_OUT      = 3'h5;
  localparam logic [1:0] VU_NONE      = 2'h0;
  localparam logic [1:0] VU_PRES      = 2'h1;
  localparam logic [1:0] VU_HIGH      = 2'h2;

  localparam logic signed [7:0] GAIN_MIN = 8'shBA;
  localparam logic signed [7:0] GAIN_MAX = 8'sh0C;
  localparam logic [7:0]        GAIN_OFS = 8'h48;
  localparam logic [7:0]        DB_STEP  = 8'h06;
  // 2^(n/6) in 1/4096 units, n = 0..5
  localparam logic [5:0][12:0] GAIN_STEP = {13'h1C82, 13'h1966, 13'h16A1,
                                            13'h1429, 13'h11F6, 13'h1000};
  // clip, then 2/4/6/8/10 dB below full scale
  localparam logic [5:0][23:0] PEAK_THR = {24'h28_7A2D, 24'h32_F547, 24'h40_26FE,
                                           24'h50_C49B, 24'h65_ABE4, 24'h7F_FFFF};
  localparam logic [23:0] REF_M20 = 24'h0C_CCCD;
  localparam logic [23:0] REF_M18 = 24'h10_1D35;
  localparam logic [23:0] REF_M40 = 24'h01_47AE;
  localparam logic [23:0] REF_M38 = 24'h01_9C85;
  localparam logic signed [23:0] SAMPLE_MAX = 24'sh7F_FFFF;
  localparam logic signed [23:0] SAMPLE_MIN = 24'sh80_0000;

  localparam logic [6:0] VOL_MAX = 7'h64;
  localparam logic [9:0] VOL_K   = 10'h28F;

  localparam int SAMPLE_RATE_HZ = 32'h0000_BB80;
  localparam int MS_PER_S       = 32'h0000_03E8;
  localparam int SAMPLES_PER_MS = SAMPLE_RATE_HZ / MS_PER_S;
  localparam int DELAY_MS_DFLT  = 32'h0000_03E8;
  localparam int TICK_TO_OUT    = 32'h0000_000C;
endpackage

// ---- testbench/aes_emb_source.sv ----
// behavioural stand-in for the AES receivers and the embedded audio path
// assumes level, kinds and presence are set by the bench between frames
`timescale 1ns/1ps
module aes_emb_source (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire mix_pkg::sample_t level,
  input  wire logic [3:0][2:0]  kind_set,
  input  wire logic [3:0]       present_set,
  input  wire logic             slow,
  output mix_pkg::aes_bus_t     aes_in,
  output logic [3:0]            aes_in_valid,
  output logic [3:0][2:0]       aes_kind,
  output mix_pkg::emb_bus_t     emb_in,
  output logic [3:0]            emb_present
);
  logic [5:0] cnt_ff;
  logic       fire;

  // slow pacing mimics an asynchronous source well below the frame rate
  assign fire = slow ? (cnt_ff == 6'h3F) : (cnt_ff[2:0] == 3'h7);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff       <= 6'h00;
      aes_in_valid <= 4'h0;
      aes_in       <= '0;
    end else begin
      cnt_ff       <= cnt_ff + 6'h01;
      aes_in_valid <= {4{fire}};
      // between words the receiver output is not held, so show the inverse
      for (int i = 0; i < 8; i++) begin
        aes_in[i] <= fire ? level + mix_pkg::sample_t'(i) : ~(level + mix_pkg::sample_t'(i));
      end
    end
  end

  always_comb begin
    aes_kind    = kind_set;
    emb_present = present_set;
    for (int k = 0; k < 16; k++) begin
      emb_in[k] = level + mix_pkg::sample_t'(16'h0100 + k);
    end
  end
endmodule

// ---- testbench/audio_mux_mixer_router_tb.sv ----
// self-checking bench: register access, port modes, mixer, meters, monitor and delay
// assumes the source model stands in for the AES receivers and the de-embedder
`timescale 1ns/1ps
module audio_mux_mixer_router_tb;
  logic              clock, reset_n, wr, rd, tick, out_valid, anlg_ref_hi, slow;
  logic [7:0]        addr, peak_flag;
  logic [31:0]       wdata, rdata, rv;
  logic [3:0]        aes_in_valid, emb_present, aes_dir, present_set;
  logic [3:0][2:0]   aes_kind, kind_set;
  logic [7:0][1:0]   vu_level;
  mix_pkg::aes_bus_t aes_in, aes_out;
  mix_pkg::emb_bus_t emb_in, emb_out;
  mix_pkg::sample_t  mon_l, mon_r, disp_l, disp_r, level;
  int                fails, total_checks, n;

  audio_mux_mixer_router #(.DELAY_MAX_MS(2)) audio_mux_mixer_router_i (
    .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tick(tick), .aes_in(aes_in), .aes_in_valid(aes_in_valid),
    .aes_kind(aes_kind), .emb_in(emb_in), .emb_present(emb_present), .aes_out(aes_out),
    .aes_dir(aes_dir), .emb_out(emb_out), .out_valid(out_valid), .mon_l(mon_l),
    .mon_r(mon_r), .disp_l(disp_l), .disp_r(disp_r), .anlg_ref_hi(anlg_ref_hi),
    .peak_flag(peak_flag), .vu_level(vu_level));

  aes_emb_source aes_emb_source_i (
    .clock(clock), .reset_n(reset_n), .level(level), .kind_set(kind_set),
    .present_set(present_set), .slow(slow), .aes_in(aes_in), .aes_in_valid(aes_in_valid),
    .aes_kind(aes_kind), .emb_in(emb_in), .emb_present(emb_present));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    check(what, rdata, exp);
    @(negedge clock);
    check("rdata idle", rdata, 32'h0000_0000);
  endtask

  // each frame: one tick, then out_valid must follow after the fixed pipeline depth
  task automatic frame(input int count);
    for (int f = 0; f < count; f++) begin
      @(posedge clock);
      tick <= 1'b1;
      @(posedge clock);
      tick <= 1'b0;
      n = 0;
      while (out_valid !== 1'b1 && n < 40) begin
        @(negedge clock);
        n++;
      end
      check("frame latency", n, mix_pkg::TICK_TO_OUT);
    end
  endtask

  task automatic set_level(input mix_pkg::sample_t v);
    @(posedge clock);
    level <= v;
  endtask

  function automatic mix_pkg::sample_t av(input int i);
    return level + mix_pkg::sample_t'(i);
  endfunction

  function automatic mix_pkg::sample_t ev(input int k);
    return level + mix_pkg::sample_t'(16'h0100 + k);
  endfunction

  function automatic mix_pkg::sample_t vol_scale(input mix_pkg::sample_t s, input int pct);
    return mix_pkg::sample_t'((longint'(s) * pct * 655) >>> 16);
  endfunction

  function automatic logic [31:0] cfg(input int m, input int ga, input int gb, input int pk);
    return 32'(m) | (32'(pk) << 3) | (32'(ga) << 7) | (32'(gb) << 9);
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // the whole run needs roughly 2000 cycles; allow several times that
  initial begin
    #2_000_000;
    fails++;
    complete_run();
  end

  initial begin
    fails = 0;
    total_checks = 0;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    tick = 1'b0;
    slow = 1'b0;
    level = 24'h10_0000;
    kind_set = {3'h4, 3'h3, 3'h2, 3'h1};
    present_set = 4'b0101;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(negedge clock);
    check("dir after reset", 32'(aes_dir), 32'h0000_000C);
    check("analog ref", 32'(anlg_ref_hi), 32'h0000_0000);
    rd_chk("cfg reset", mix_pkg::REG_CFG, 32'h0000_0000);
    rd_chk("delay reset", mix_pkg::REG_DELAY, 32'h0000_0000);
    rd_chk("volume reset", mix_pkg::REG_VOL, 32'h0000_0064);
    for (int i = 0; i < 8; i++) begin
      rd_chk("chan reset", mix_pkg::REG_CH0 + 8'(4 * i), 32'h0000_0400 << i);
    end
    $display("test reset values done");

    wr_reg(mix_pkg::REG_CFG, cfg(2, 0, 7, 7));
    rd_chk("cfg clamp", mix_pkg::REG_CFG, cfg(2, 0, 4, 5));
    wr_reg(mix_pkg::REG_CFG, cfg(3, 0, 0, 0));
    rd_chk("bad mode kept", mix_pkg::REG_CFG, cfg(2, 0, 0, 0));
    wr_reg(mix_pkg::REG_DELAY, 32'h0000_0005);
    rd_chk("delay clamp", mix_pkg::REG_DELAY, 32'h0000_0002);
    wr_reg(mix_pkg::REG_VOL, 32'h0000_00C8);
    rd_chk("volume clamp", mix_pkg::REG_VOL, 32'h0000_0064);
    wr_reg(mix_pkg::REG_CH0, 32'h0000_04B0);
    rd_chk("gain floor", mix_pkg::REG_CH0, 32'h0000_04BA);
    wr_reg(mix_pkg::REG_CH0, 32'h0000_0414);
    rd_chk("gain ceiling", mix_pkg::REG_CH0, 32'h0000_040C);
    wr_reg(8'h14, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h14, 32'h0000_0000);
    wr_reg(mix_pkg::REG_CH0, 32'h0000_0400);
    wr_reg(mix_pkg::REG_DELAY, 32'h0000_0000);
    $display("test register limits done");

    for (int m = 0; m < 3; m++) begin
      wr_reg(mix_pkg::REG_CFG, cfg(m, 2, 1, 0));
      frame(1);
      check("port dir", 32'(aes_dir), m == 0 ? 32'hC : (m == 1 ? 32'h0 : 32'hF));
      rv = (m == 0) ? 32'h0000_002B : 32'h0000_0003;
      for (int p = 0; p < 4; p++) begin
        rv |= 32'((m == 2 || (m == 0 && p > 1)) ? 3'h5 : kind_set[p]) << (6 + 3 * p);
      end
      rd_chk("status", mix_pkg::REG_STAT, rv);
    end
    $display("test port modes done");

    wr_reg(mix_pkg::REG_CFG, cfg(2, 2, 1, 0));
    frame(2);
    for (int i = 0; i < 4; i++) begin
      check("demux A", aes_out[i], ev(8 + i));
      check("demux B", aes_out[4 + i], ev(4 + i));
    end
    wr_reg(mix_pkg::REG_CFG, cfg(2, 0, 4, 0));
    frame(1);
    check("demux B off", aes_out[5], 32'h0000_0000);
    rd_chk("status off", mix_pkg::REG_STAT, 32'h0002_DB69);
    $display("test demux done");

    wr_reg(mix_pkg::REG_CFG, cfg(2, 0, 1, 0));
    wr_reg(mix_pkg::REG_CH0, 32'h0000_0406);
    wr_reg(mix_pkg::REG_CH0 + 8'h04, 32'h0000_0900);
    wr_reg(mix_pkg::REG_CH0 + 8'h08, 32'h0000_2000);
    wr_reg(mix_pkg::REG_CH0 + 8'h10, 32'h0000_4206);
    frame(1);
    check("gain 6 dB", aes_out[0], 2 * ev(0));
    check("invert", aes_out[1], -ev(1));
    check("unrouted", aes_out[2], 32'h0000_0000);
    check("summed", aes_out[3], ev(2) + ev(3));
    check("tie even", aes_out[4], 2 * ev(4));
    check("tie odd", aes_out[5], 2 * ev(5));
    check("mixer B", aes_out[6], ev(6));
    for (int i = 0; i < 8; i++) begin
      wr_reg(mix_pkg::REG_CH0 + 8'(4 * i), 32'h0000_0400 << i);
    end
    $display("test mixer done");

    set_level(24'h30_0000);
    wr_reg(mix_pkg::REG_CH0, 32'h0000_040C);
    wr_reg(mix_pkg::REG_CFG, cfg(2, 0, 0, 0));
    frame(2);
    check("saturate", aes_out[0], mix_pkg::SAMPLE_MAX);
    check("clip peak", 32'(peak_flag), 32'h0000_0001);
    check("vu high", 32'(vu_level), 32'h0000_AAAA);
    wr_reg(mix_pkg::REG_CH0, 32'h0000_0400);
    wr_reg(mix_pkg::REG_CFG, cfg(2, 0, 0, 5));
    frame(1);
    rd_chk("level reg", mix_pkg::REG_LEVEL, 32'h00AA_AAFF);
    set_level(24'h0F_0000);
    wr_reg(mix_pkg::REG_CFG, cfg(2, 0, 0, 0));
    frame(1);
    check("vu ref -20", 32'(vu_level), 32'h0000_AAAA);
    wr_reg(mix_pkg::REG_CFG, cfg(2, 0, 0, 0) | 32'h0000_0004);
    frame(1);
    check("vu ref -18", 32'(vu_level), 32'h0000_5555);
    set_level(24'h00_1000);
    frame(1);
    check("vu none", 32'(vu_level), 32'h0000_0000);
    $display("test meters done");

    set_level(24'h01_0000);
    slow <= 1'b1;
    wr_reg(mix_pkg::REG_VOL, 32'h0000_0032);
    wr_reg(mix_pkg::REG_CFG, cfg(1, 1, 3, 0) | 32'h0003_9040);
    frame(6);
    for (int i = 0; i < 4; i++) begin
      check("mux8 group A", emb_out[4 + i], av(i));
      check("mux8 group B", emb_out[12 + i], av(4 + i));
      check("mux8 aes off", aes_out[i], 32'h0000_0000);
    end
    // pair 3/4 is group 1, which mux8 with groups 2 and 4 passes through untouched
    check("mon left", mon_l, vol_scale(ev(2), 50));
    check("mon right", mon_r, vol_scale(ev(3), 50));
    check("disp left", disp_l, av(6));
    check("disp right", disp_r, av(7));
    check("analog +4", 32'(anlg_ref_hi), 32'h0000_0001);
    wr_reg(mix_pkg::REG_CFG, cfg(0, 2, 0, 0));
    frame(6);
    for (int i = 0; i < 4; i++) begin
      check("mux4 insert", emb_out[8 + i], av(i));
      check("mux4 out", aes_out[4 + i], ev(8 + i));
      check("mux4 in side", aes_out[i], 32'h0000_0000);
    end
    $display("test mux modes done");

    @(posedge clock);
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
    repeat (3) @(posedge clock);
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
    n = 0;
    repeat (30) begin
      @(negedge clock);
      n += int'(out_valid === 1'b1);
    end
    check("tick in flight", n, 1);
    $display("test frame timing done");

    set_level(24'h00_1000);
    wr_reg(mix_pkg::REG_CFG, cfg(2, 0, 0, 0));
    wr_reg(mix_pkg::REG_DELAY, 32'h0000_0001);
    frame(50);
    set_level(24'h00_2000);
    frame(48);
    check("delayed old", aes_out[0], 24'h00_1100);
    frame(1);
    check("delayed new", aes_out[0], 24'h00_2100);
    $display("test delay done");
    complete_run();
  end
endmodule
